// *** rtl/burst_sram_access.sv ***
// Purpose: access control of a pipelined synchronous burst memory
// Assumes: all bus pins come from outside and are synchronised here
// Notes:   the data pin is split into in, out and enable (low = driving)
`timescale 1ns/100ps
`include "burst_sram_consts.svh"

//------------------------------------------------------------
// contract
//------------------------------------------------------------
// Contract
// RL1: read starts when a strobe is low, selects active, writes idle
// RL2: access start loads address register and burst counter, array sees address
// RL3: read data leaves output register after next rise when output enable low
// RL4: first cycle after deselect to select keeps data tristated
// RL5: back-to-back single reads need no idle cycle
// RL6: deselect through selects and strobe tristates data at once
// RL7: first cycle of processor-strobe access ignores writes and advance
// RL8: processor-strobe write takes two cycles; global write at second writes
// RL9: with global write high, byte enable and lane selects choose bytes
// RL10: unselected bytes stay unchanged in the array
// RL11: data outputs tristate whenever a write cycle is seen
// RL12: master raises output enable before driving write data; the bench drives one controller write with output enable low
// RL13: controller-strobe write: controller low, processor high, selects, write inputs
// RL14: controller-strobe write takes one cycle, advance ignored
// RL15: two-bit wraparound counter from low address bits, order by strap
// RL16: advance low at a rise steps the counter, reads and writes
// RL17: interleaved order is start XOR 0,1,2,3
// RL18: sleep request enters low-power sleep; entry and exit two cycles each
// RL19: contents kept in sleep; pending access dropped, not valid
// RL20: master deselects before raising sleep request
// RL21: master keeps selects and strobes idle through sleep recovery time
// RL22: linear order counts up from start modulo four
// RL23: burst order strap static: low linear, high interleaved
// RL24: global write low writes every byte lane
// RL25: processor strobe ignored while primary select is high
module burst_sram_access #(
	parameter int ADDR_W = `ADDR_W_DEF,
	parameter int LANES  = `LANES_DEF,
	parameter int LANE_W = `LANE_W_DEF
) (
	// clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	// address and selects
	input  wire logic [ADDR_W-1:0]       addrIn,
	input  wire logic                    chipSel1N,
	input  wire logic                    chipSel2,
	input  wire logic                    chipSel3N,
	// strobes and burst control
	input  wire logic                    processor_addr_strobe_n,
	input  wire logic                    controller_addr_strobe_n,
	input  wire logic                    burst_advance_n,
	// write control
	input  wire logic                    global_write_n,
	input  wire logic                    byte_write_enable_n,
	input  wire logic [LANES-1:0]        byte_lane_select_n,
	// output enable, sleep and burst order strap
	input  wire logic                    outEnableN,
	input  wire logic                    sleep_request,
	input  wire logic                    burstOrderStrap,
	// data pins
	input  wire logic [LANES*LANE_W-1:0] dataIn,
	output logic      [LANES*LANE_W-1:0] dataOut,
	output logic                         dataOeN,
	// status
	output logic                         sleeping
);
	localparam int DW = LANES * LANE_W;

	typedef struct packed {
		burst_sram_pkg::bus_ctrl_t  ctl1;
		burst_sram_pkg::bus_ctrl_t  ctl2;
		logic [ADDR_W-1:0]          addr1;
		logic [ADDR_W-1:0]          addr2;
		logic [DW-1:0]              data1;
		logic [DW-1:0]              data2;
		logic                       strap1;
		logic                       strap2;
		logic                       linearMode;
		burst_sram_pkg::acc_state_t acc;
		logic                       selected;
		logic [ADDR_W-1:0]          baseAddr;
		logic [`BURST_W-1:0]        startLow;
		logic [`BURST_W-1:0]        burstCnt;
		logic                       firstCycle;
		logic                       outValid;
		logic [DW-1:0]              outData;
		logic                       oeN;
		burst_sram_pkg::slp_state_t slp;
		logic [`SLEEP_CNT_W-1:0]    slpCnt;
		logic                       asleep;
	} top_st_t;

	top_st_t                   st_ff;
	top_st_t                   nxt_st;
	burst_sram_pkg::bus_ctrl_t pinCtl;
	burst_sram_pkg::bus_ctrl_t c;
	burst_sram_pkg::wr_word_t  wrPush;
	burst_sram_pkg::wr_word_t  wrHead;
	logic                      wrPushValid;
	logic                      wrPushReady;
	logic                      wrHeadValid;
	logic [DW-1:0]             rdData;
	logic [ADDR_W-1:0]         curAddr;
	logic [ADDR_W-1:0]         rdAddr;
	logic [`BURST_W-1:0]       burstOff;
	logic [`BURST_W-1:0]       nextOff;
	logic [ADDR_W-1:0]         nextAddr;

	//------------------------------------------------------------
	// pin gathering
	//------------------------------------------------------------
	assign pinCtl = '{cs1N: chipSel1N, cs2: chipSel2, cs3N: chipSel3N,
		procStrobeN: processor_addr_strobe_n, ctrlStrobeN: controller_addr_strobe_n,
		advN: burst_advance_n, gwN: global_write_n, bweN: byte_write_enable_n,
		laneN: byte_lane_select_n, oeN: outEnableN, sleepReq: sleep_request};
	assign c = st_ff.ctl2;

	// counter value in the chosen order; the strap passes three flip-flops and is resampled every cycle
	assign burstOff = st_ff.linearMode ? st_ff.startLow + st_ff.burstCnt   // RL22
		: st_ff.startLow ^ st_ff.burstCnt;                                  // RL17
	assign curAddr  = {st_ff.baseAddr[ADDR_W-1:`BURST_W], burstOff};       // RL15
	// address one step on; a beat that advances uses it in the same cycle
	assign nextOff  = st_ff.linearMode ? st_ff.startLow + st_ff.burstCnt + `BURST_STEP // RL22
		: st_ff.startLow ^ (st_ff.burstCnt + `BURST_STEP);                  // RL17
	assign nextAddr = {st_ff.baseAddr[ADDR_W-1:`BURST_W], nextOff};

	// write path: array is written from the fifo head, drained every cycle while not asleep
	word_fifo #(
		.WIDTH ($bits(burst_sram_pkg::wr_word_t)),
		.DEPTH (`WFIFO_DEPTH)
	) uWrFifo (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.inValid  (wrPushValid),
		.inReady  (wrPushReady),
		.inData   (wrPush),
		.outValid (wrHeadValid),
		.outReady (!st_ff.asleep),
		.outData  (wrHead)
	);

	burst_sram_array #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_W)
	) uArray (
		.clk_sys (clk_sys),
		.wrEn    (wrHeadValid && !st_ff.asleep),
		.wrAddr  (wrHead.addr),
		.wrLanes (wrHead.lanes),
		.wrData  (wrHead.data),
		.rdAddr  (rdAddr),
		.rdData  (rdData)
	);

	//------------------------------------------------------------
	// access control
	//------------------------------------------------------------
	// decodes work on the synchronised copy of the pins
	always_comb begin
		logic allSel;
		logic procStart;
		logic ctrlStart;
		logic anyWrite;
		logic deselect;
		logic [LANES-1:0] lanes;
		allSel    = 1'b0;
		procStart = 1'b0;
		ctrlStart = 1'b0;
		anyWrite  = 1'b0;
		deselect  = 1'b0;
		lanes     = '0;
		nxt_st    = st_ff;
		rdAddr    = curAddr;
		wrPushValid = 1'b0;
		wrPush    = '0;

		// two flip-flops on every pin before any decode
		nxt_st.ctl1   = pinCtl;
		nxt_st.ctl2   = st_ff.ctl1;
		nxt_st.addr1  = addrIn;
		nxt_st.addr2  = st_ff.addr1;
		nxt_st.data1  = dataIn;
		nxt_st.data2  = st_ff.data1;
		nxt_st.strap1 = burstOrderStrap;
		nxt_st.strap2 = st_ff.strap1;
		nxt_st.oeN    = c.oeN;

		allSel    = !c.cs1N && c.cs2 && !c.cs3N;
		procStart = !c.procStrobeN && !c.cs1N;                            // RL25
		ctrlStart = !c.ctrlStrobeN && c.procStrobeN;
		// global write overrides lane selects
		lanes     = !c.gwN ? {LANES{1'b1}}                                 // RL24
			: (!c.bweN ? ~c.laneN : '0);                                    // RL9
		anyWrite  = |lanes;
		deselect  = (procStart || !c.ctrlStrobeN) && !allSel;

		// sleep sequencing: two cycles in, two out
		case (st_ff.slp)
			burst_sram_pkg::SLP_AWAKE: begin
				if (c.sleepReq) begin
					nxt_st.slp    = burst_sram_pkg::SLP_ENTER;
					nxt_st.slpCnt = '0;
				end
			end
			burst_sram_pkg::SLP_ENTER: begin
				nxt_st.slpCnt = st_ff.slpCnt + 1'b1;
				if (st_ff.slpCnt == `SLEEP_CNT_W'(`SLEEP_ENTER_CYC - 1)) begin
					nxt_st.slp    = burst_sram_pkg::SLP_ASLEEP;                // RL18
					nxt_st.asleep = 1'b1;
				end
			end
			burst_sram_pkg::SLP_ASLEEP: begin
				if (!c.sleepReq) begin
					nxt_st.slp    = burst_sram_pkg::SLP_EXIT;
					nxt_st.slpCnt = '0;
				end
			end
			burst_sram_pkg::SLP_EXIT: begin
				nxt_st.slpCnt = st_ff.slpCnt + 1'b1;
				if (st_ff.slpCnt == `SLEEP_CNT_W'(`SLEEP_EXIT_CYC - 1)) begin
					nxt_st.slp    = burst_sram_pkg::SLP_AWAKE;                 // RL18
					nxt_st.asleep = 1'b0;
				end
			end
			default: begin
				nxt_st.slp = burst_sram_pkg::SLP_AWAKE;
			end
		endcase

		// output register defaults: nothing valid unless a read leaves it
		nxt_st.outValid   = 1'b0;
		nxt_st.firstCycle = 1'b0;

		if (st_ff.slp != burst_sram_pkg::SLP_AWAKE || c.sleepReq) begin
			// pending access dropped, array untouched
			nxt_st.acc      = burst_sram_pkg::ACC_IDLE;                       // RL19
			nxt_st.selected = 1'b0;
		end else if (deselect) begin
			nxt_st.acc      = burst_sram_pkg::ACC_IDLE;
			nxt_st.selected = 1'b0;                                           // RL6
		end else if (procStart || (!c.ctrlStrobeN && allSel)) begin
			// capture address, reset counter, present address to the array
			nxt_st.baseAddr = st_ff.addr2;                                    // RL2
			nxt_st.startLow = st_ff.addr2[`BURST_W-1:0];                      // RL15
			nxt_st.burstCnt = '0;
			rdAddr          = st_ff.addr2;
			nxt_st.selected = 1'b1;
			nxt_st.firstCycle = !st_ff.selected;                              // RL4
			if (procStart) begin
				// write inputs and advance are not looked at this cycle
				nxt_st.acc      = burst_sram_pkg::ACC_WRITE2;                  // RL7
				nxt_st.outValid = 1'b1;                                        // RL1
				nxt_st.outData  = rdData;
			end else if (ctrlStart && anyWrite) begin
				wrPushValid = wrPushReady;                                     // RL13
				wrPush      = '{addr: st_ff.addr2, lanes: lanes, data: st_ff.data2};
				nxt_st.acc  = burst_sram_pkg::ACC_IDLE;                        // RL14
			end else begin
				nxt_st.acc      = burst_sram_pkg::ACC_READ;                    // RL5
				nxt_st.outValid = 1'b1;                                        // RL1
				nxt_st.outData  = rdData;
			end
		end else if (st_ff.selected && !procStart && c.ctrlStrobeN) begin     // RL25
			// continuing or second cycle: advance steps the counter
			if (!c.advN) begin
				nxt_st.burstCnt = st_ff.burstCnt + `BURST_STEP;                // RL16
				rdAddr          = nextAddr;
			end
			if (anyWrite) begin
				// second rise of a processor write, or a burst write beat
				wrPushValid = wrPushReady;                                     // RL8
				wrPush      = '{addr: rdAddr, lanes: lanes, data: st_ff.data2};
				nxt_st.acc  = burst_sram_pkg::ACC_IDLE;
			end else begin
				nxt_st.acc      = burst_sram_pkg::ACC_READ;
				nxt_st.outValid = 1'b1;                                        // RL3
				nxt_st.outData  = rdData;
			end
		end

		// a write seen this cycle blanks the outputs
		if (wrPushValid) begin
			nxt_st.outValid = 1'b0;                                            // RL11
		end
		nxt_st.linearMode = !st_ff.strap2;                                     // RL23
	end

	// state in one clocked process, outputs in a second; contents of the array are not reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_ff     <= '0;
			st_ff.ctl1 <= '1;
			st_ff.ctl2 <= '1;
			// sleep request idles low; a high here would start a sleep after reset
			st_ff.ctl1.sleepReq <= 1'b0;
			st_ff.ctl2.sleepReq <= 1'b0;
			st_ff.oeN <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	// driver enable: only after first cycle, never during writes or sleep
	logic drive_ff;
	logic [DW-1:0] dout_ff;
	logic sleep_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			drive_ff <= 1'b0;
			dout_ff  <= '0;
			sleep_ff <= 1'b0;
		end else begin
			drive_ff <= nxt_st.outValid && !nxt_st.firstCycle && !nxt_st.oeN
				&& !nxt_st.asleep;                                             // RL4
			dout_ff  <= nxt_st.outData;
			sleep_ff <= nxt_st.asleep;
		end
	end
	assign dataOeN  = !drive_ff;                                               // RL3
	assign dataOut  = dout_ff;
	assign sleeping = sleep_ff;
endmodule

// *** rtl/burst_sram_array.sv ***
// Purpose: memory array with per-lane write and combinational read from rdAddr
// Assumes: one clock
// Notes:   contents survive sleep since nothing here resets them
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
module burst_sram_array #(
	parameter int ADDR_W = `ADDR_W_DEF,
	parameter int LANES  = `LANES_DEF,
	parameter int LANE_W = `LANE_W_DEF
) (
	// clock
	input  wire logic                    clk_sys,
	// write port
	input  wire logic                    wrEn,
	input  wire logic [ADDR_W-1:0]       wrAddr,
	input  wire logic [LANES-1:0]        wrLanes,
	input  wire logic [LANES*LANE_W-1:0] wrData,
	// read port
	input  wire logic [ADDR_W-1:0]       rdAddr,
	output logic      [LANES*LANE_W-1:0] rdData
);
	// one storage column per lane, so each column has a single writer
	// and unselected lanes keep their old contents
	for (genvar g = 0; g < LANES; g++) begin : gLane
		logic [LANE_W-1:0] laneMem_ff [2**ADDR_W];

		assign rdData[g*LANE_W +: LANE_W] = laneMem_ff[rdAddr];

		always_ff @(posedge clk_sys) begin
			if (wrEn && wrLanes[g]) begin
				laneMem_ff[wrAddr] <= wrData[g*LANE_W +: LANE_W]; // RL10
			end
		end
	end
endmodule

// *** rtl/burst_sram_consts.svh ***
// Purpose: timing counts and sizes of the pipelined burst memory access block
// Assumes: clk_sys at 50 MHz
// Notes:   definitions only
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH

`define CLK_PERIOD_NS      20
// sleep entry and exit, in clock cycles as printed
`define SLEEP_ENTER_CYC    2
`define SLEEP_EXIT_CYC     2
`define SLEEP_CNT_W        2
// burst counter
`define BURST_W            2
`define BURST_STEP         2'h1
// fifo depth of the write path
`define WFIFO_DEPTH        16
// default geometry
`define ADDR_W_DEF         10
`define LANES_DEF          4
`define LANE_W_DEF         9

`endif

// *** rtl/burst_sram_pkg.sv ***
// Purpose: shared types of the pipelined burst memory access block
// Assumes: geometry fixed by the header defaults
// Notes:   no constants live here, only types
`include "burst_sram_consts.svh"
package burst_sram_pkg;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE2
	} acc_state_t;

	typedef enum logic [1:0] {
		SLP_AWAKE,
		SLP_ENTER,
		SLP_ASLEEP,
		SLP_EXIT
	} slp_state_t;

	// one write waiting for the array
	typedef struct packed {
		logic [`ADDR_W_DEF-1:0]                  addr;
		logic [`LANES_DEF-1:0]                   lanes;
		logic [`LANES_DEF*`LANE_W_DEF-1:0]       data;
	} wr_word_t;

	// control pins gathered before synchronisation
	typedef struct packed {
		logic                       cs1N;
		logic                       cs2;
		logic                       cs3N;
		logic                       procStrobeN;
		logic                       ctrlStrobeN;
		logic                       advN;
		logic                       gwN;
		logic                       bweN;
		logic [`LANES_DEF-1:0]      laneN;
		logic                       oeN;
		logic                       sleepReq;
	} bus_ctrl_t;

endpackage

// *** rtl/word_fifo.sv ***
// Purpose: parameterised flip-flop fifo with valid and ready on both sides
// Assumes: one clock, synchronous active high reset
// Notes:   full and empty come from a count, so depth need not be a power of two
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `WFIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [PW:0]   count;
	} fifo_st_t;

	fifo_st_t         st_ff;
	fifo_st_t         nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic             doPush;
	logic             doPop;

	assign inReady  = (st_ff.count != (PW+1)'(DEPTH));
	assign outValid = (st_ff.count != '0);
	assign outData  = mem_ff[st_ff.rdPtr];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// pointer and count update; pointers wrap at depth
	always_comb begin
		nxt_st = st_ff;
		if (doPush) begin
			nxt_st.wrPtr = (st_ff.wrPtr == PW'(DEPTH-1)) ? '0 : st_ff.wrPtr + 1'b1;
		end
		if (doPop) begin
			nxt_st.rdPtr = (st_ff.rdPtr == PW'(DEPTH-1)) ? '0 : st_ff.rdPtr + 1'b1;
		end
		nxt_st.count = st_ff.count + (PW+1)'(doPush) - (PW+1)'(doPop);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// storage needs no reset
	always_ff @(posedge clk_sys) begin
		if (doPush) begin
			mem_ff[st_ff.wrPtr] <= inData;
		end
	end
endmodule

// *** sim/burst_sram_access_assertions.sv ***
// Purpose: port-level assertions of the burst memory access block
// Assumes: outputs appear three edges after the pins that cause them
// Notes:   bound from the bench top
`timescale 1ns/100ps
module burst_sram_access_checker #(
	parameter int ADDR_W = 10,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	// clock and reset
	input wire logic                    clk_sys,
	input wire logic                    sys_rst,
	// pins seen by the block
	input wire logic                    chipSel1N,
	input wire logic                    chipSel2,
	input wire logic                    chipSel3N,
	input wire logic                    processor_addr_strobe_n,
	input wire logic                    controller_addr_strobe_n,
	input wire logic                    global_write_n,
	input wire logic                    byte_write_enable_n,
	input wire logic [LANES-1:0]        byte_lane_select_n,
	input wire logic                    outEnableN,
	input wire logic                    sleep_request,
	// outputs
	input wire logic [LANES*LANE_W-1:0] dataOut,
	input wire logic                    dataOeN,
	input wire logic                    sleeping
);
	//------------------------------------------------------------
	// sequences
	//------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// any write request on the pins
	logic wrAny;
	assign wrAny = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));

	sequence s_sel;
		!chipSel1N && chipSel2 && !chipSel3N;
	endsequence
	sequence s_desel;
		chipSel1N && !controller_addr_strobe_n;
	endsequence
	sequence s_rd_start;
		!chipSel1N && chipSel2 && !chipSel3N && global_write_n && byte_write_enable_n
			&& !(controller_addr_strobe_n && processor_addr_strobe_n);
	endsequence
	sequence s_ctrl_wr;
		!chipSel1N && chipSel2 && !chipSel3N && !controller_addr_strobe_n
			&& processor_addr_strobe_n && wrAny;
	endsequence

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	a_reset_idle: assert property ($fell(sys_rst) |-> dataOeN && !sleeping && dataOut == '0)
		else $error("outputs not idle after reset");
	a_oe_off: assert property (outEnableN [*5] |-> dataOeN)
		else $error("data driven with output enable high");
	a_write_quiet: assert property (s_ctrl_wr |-> ##3 dataOeN)
		else $error("data driven in a write cycle");
	a_desel_quiet: assert property (s_desel |-> ##3 dataOeN)
		else $error("data driven after deselect");
	a_first_quiet: assert property (s_desel ##1 s_rd_start |-> ##3 dataOeN)
		else $error("data driven in first cycle after deselect");
	a_b2b_drive: assert property (s_rd_start ##1 (s_rd_start and !outEnableN) |-> ##3 !dataOeN)
		else $error("back to back read not driven");
	a_sleep_in: assert property ($rose(sleep_request) |-> ##[1:8] sleeping)
		else $error("sleep not entered in time");
	a_sleep_out: assert property ($fell(sleep_request) |-> ##[1:8] !sleeping)
		else $error("sleep not left in time");
	a_sleep_quiet: assert property (sleeping |-> dataOeN)
		else $error("data driven while asleep");
endmodule

// *** sim/pipelined_burst_sram_access_tb_top.sv ***
// Purpose: self-checking bench of the burst memory access block
// Assumes: reference image holds every word written so far
// Notes:   first beat after a deselect is never driven, so it is not expected
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
`define CHK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module pipelined_burst_sram_access_tb_top;
	localparam int AW = `ADDR_W_DEF;
	localparam int LN = `LANES_DEF;
	localparam int LW = `LANE_W_DEF;
	localparam int DW = LN * LW;

	logic                      clk_sys = 1'b0;
	logic                      sys_rst = 1'b1;
	logic                      strap   = 1'b1;
	burst_sram_pkg::bus_ctrl_t pin;
	logic [AW-1:0]             addr;
	logic [DW-1:0]             wdata;
	logic [DW-1:0]             dataOut;
	logic [DW-1:0]             want;
	logic                      dataOeN;
	logic                      sleeping;
	logic [DW-1:0]             mem [int];
	logic [DW-1:0]             expQ [$];
	int                        n_errors = 0;
	int                        compares = 0;
	int                        cycles   = 0;
	int                        seed     = 32'h8520;
	int                        base;

	//------------------------------------------------------------
	// clock, parts and monitor
	//------------------------------------------------------------
	always #10 clk_sys = ~clk_sys;

	burst_sram_access DUT (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .addrIn(addr),
		.chipSel1N(pin.cs1N), .chipSel2(pin.cs2), .chipSel3N(pin.cs3N),
		.processor_addr_strobe_n(pin.procStrobeN), .controller_addr_strobe_n(pin.ctrlStrobeN),
		.burst_advance_n(pin.advN), .global_write_n(pin.gwN), .byte_write_enable_n(pin.bweN),
		.byte_lane_select_n(pin.laneN), .outEnableN(pin.oeN), .sleep_request(pin.sleepReq),
		.burstOrderStrap(strap), .dataIn(wdata), .dataOut(dataOut), .dataOeN(dataOeN),
		.sleeping(sleeping)
	);
	sram_bus_master #(.AW(AW), .DW(DW), .LN(LN)) bfm (
		.clk_sys(clk_sys), .pin(pin), .addr(addr), .wdata(wdata)
	);

	// each driven beat must match the oldest outstanding read
	always @(negedge clk_sys) begin
		if (!sys_rst && dataOeN === 1'b0) begin
			want = expQ.size() != 0 ? expQ.pop_front() : ~dataOut;
			`CHK(dataOut, want)
		end
	end

	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			conclude();
		end
	end

	//------------------------------------------------------------
	// model tasks
	//------------------------------------------------------------
	task automatic conclude();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// random word; only selected lanes reach the image
	task automatic mwrite(input int a, input bit proc, input logic gwN, input logic bweN,
		input logic [LN-1:0] laneN, input logic oe);
		logic [DW-1:0] d;
		d = DW'({$random(seed), $random(seed)});
		for (int i = 0; i < LN; i++)
			if (!gwN || (!bweN && !laneN[i]))
				mem[a][i*LW +: LW] = d[i*LW +: LW];
		bfm.wr(AW'(a), proc, gwN, bweN, laneN, oe, d);
		bfm.idle(1, 0);
	endtask

	// expected beats follow the strap order inside the aligned group of four
	task automatic mread(input int a, input bit proc, input int beats, input bit fresh);
		int off;
		for (int k = 0; k < beats; k++) begin
			off = strap ? ((a ^ k) & 3) : ((a + k) & 3);
			if (!(fresh && k == 0))
				expQ.push_back(mem[(a & ~3) | off]);
		end
		bfm.rd(AW'(a), proc, beats);
	endtask

	//------------------------------------------------------------
	// main sequence, once per burst order
	//------------------------------------------------------------
	initial begin
		for (int ord = 0; ord < 2; ord++) begin
			@(negedge clk_sys);
			sys_rst = 1'b1;
			strap = ord[0];
			repeat (8) @(negedge clk_sys);
			sys_rst = 1'b0;
			base = $random(seed) & 32'h3fc;
			for (int k = 0; k < 4; k++)
				mwrite(base + k, 0, 1'b0, 1'b1, '1, 1'b1);
			mwrite(base + 1, 0, 1'b1, 1'b0, LN'($random(seed) & 32'he), 1'b0);
			mwrite(base + 2, 1, 1'b1, 1'b0, 4'h5, 1'b1);
			mwrite(base + 3, 1, 1'b0, 1'b1, '1, 1'b1);
			bfm.idle(8, 0);
			for (int s = 0; s < 4; s++) begin
				mread(base + s, 0, 4, 1);
				bfm.idle(2, 0);
			end
			mread(base + 1, 1, 1, 1);
			mread(base + 2, 1, 1, 0);
			mread(base + 3, 1, 1, 0);
			bfm.idle(8, 0);
			bfm.idle(1, 1);
			bfm.zz(1'b1);
			for (int k = 0; k < 20 && sleeping !== 1'b1; k++) @(negedge clk_sys);
			`CHK(sleeping, 1'b1)
			bfm.idle(4, 1);
			bfm.zz(1'b0);
			for (int k = 0; k < 20 && sleeping !== 1'b0; k++) @(negedge clk_sys);
			`CHK(sleeping, 1'b0)
			bfm.idle(6, 1);
			bfm.idle(2, 0);
			mread(base, 0, 4, 1);
			bfm.idle(8, 0);
			`CHK(32'(expQ.size()), 32'h0)
		end
		conclude();
	end
endmodule

bind burst_sram_access burst_sram_access_checker #(
	.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)
) chk (
	.clk_sys, .sys_rst, .chipSel1N, .chipSel2, .chipSel3N, .processor_addr_strobe_n,
	.controller_addr_strobe_n, .global_write_n, .byte_write_enable_n, .byte_lane_select_n,
	.outEnableN, .sleep_request, .dataOut, .dataOeN, .sleeping
);

// *** sim/sram_bus_master.sv ***
// Purpose: processor side model driving the burst memory pins
// Assumes: pins change only at the falling edge
// Notes:   released data lines are inverted again on every idle cycle
`timescale 1ns/100ps
`include "burst_sram_consts.svh"
module sram_bus_master #(
	parameter int AW = 10,
	parameter int DW = 36,
	parameter int LN = 4
) (
	// clock
	input  wire logic                 clk_sys,
	// pins toward the memory
	output burst_sram_pkg::bus_ctrl_t pin,
	output logic [AW-1:0]             addr,
	output logic [DW-1:0]             wdata
);
	// deselected, static selects two and three active
	initial begin
		pin = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '1, 1'b1, 1'b0};
		addr = '0;
		wdata = '0;
	end

	// idle cycles; quiet keeps every strobe high so nothing is selected
	task automatic idle(input int n, input bit quiet);
		repeat (n) begin
			@(negedge clk_sys);
			pin.cs1N = 1'b1;
			pin.ctrlStrobeN = quiet;
			pin.procStrobeN = 1'b1;
			pin.advN = 1'b1;
			pin.gwN = 1'b1;
			pin.bweN = 1'b1;
			wdata = ~wdata;
		end
	endtask

	// first cycle of any access
	task automatic start(input logic [AW-1:0] a, input bit proc, input logic oe);
		@(negedge clk_sys);
		pin.cs1N = 1'b0;
		pin.procStrobeN = !proc;
		pin.ctrlStrobeN = proc;
		pin.advN = 1'b1;
		pin.oeN = oe;
		addr = a;
	endtask

	// controller write in one cycle, processor write in two
	task automatic wr(input logic [AW-1:0] a, input bit proc, input logic gwN,
		input logic bweN, input logic [LN-1:0] laneN, input logic oe, input logic [DW-1:0] d);
		start(a, proc, oe);
		pin.gwN = proc ? 1'b0 : gwN;
		pin.bweN = bweN;
		pin.laneN = laneN;
		wdata = d;
		if (proc) begin
			@(negedge clk_sys);
			pin.procStrobeN = 1'b1;
			pin.gwN = gwN;
		end
	endtask

	// read start then advance beats with a strobe that must be ignored
	task automatic rd(input logic [AW-1:0] a, input bit proc, input int beats);
		start(a, proc, 1'b0);
		pin.gwN = 1'b1;
		pin.bweN = 1'b1;
		repeat (beats - 1) begin
			@(negedge clk_sys);
			pin.cs1N = 1'b1;
			pin.procStrobeN = 1'b0;
			pin.ctrlStrobeN = 1'b1;
			pin.advN = 1'b0;
			addr = ~addr;
		end
	endtask

	// sleep request level
	task automatic zz(input logic v);
		@(negedge clk_sys);
		pin.sleepReq = v;
	endtask
endmodule
